// ==== hdl/qdac_serial_load_ctrl.sv ====
/*
 * Top of the quad DAC serial load controller: serial frame intake,
 * package address filter, four input registers, four DAC latches,
 * load and clear control, and an AXI4-Lite register slave.
 * Assumes clk_sys at 200 MHz, rst synchronous active high, and a host
 * that keeps frame_sync_n high for at least four clk_sys cycles.
 * Clear reaches sense_ground_level three clk_sys edges after the pin
 * falls, since the control pins pass the two-stage synchroniser first.
 */
`timescale 1ns/100ps
`include "qdac_defines.svh"

// Behaviour
// - Serial data shifts into the input register on each falling serial clock edge while frame sync is low.
// - Five strap pins form the package identity compared with each frame.
// - With bypass low, only frames carrying our package address are committed.
// - With bypass high, package address is ignored; channel address still selects.
// - Rising frame sync moves the 14-bit data field of the 24-bit word into the addressed input register.
// - Load input high: input registers update, latches and outputs stay unchanged unless a CTRL soft load is written.
// - Load input low: all four input registers copy into latches together.
// - Clear low forces every output to the sense ground level.
// - After clear rises, outputs stay at sense ground until load goes low or a CTRL soft load is written.
// - After clear release, load low copies the input registers into the latches and returns outputs to them.
// - While clear is low the load input is ignored entirely.
module qdac_serial_load_ctrl
   import qdac_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   // Serial link
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic frame_sync_n,
   // Strap and control pins
   input wire logic [4:0] package_id_straps,
   input wire logic package_match_bypass,
   input wire logic load_outputs_n,
   input wire logic output_clear_n,
   // Output drive
   output logic [`QD_DATA_W-1:0] dac_code_ch0,
   output logic [`QD_DATA_W-1:0] dac_code_ch1,
   output logic [`QD_DATA_W-1:0] dac_code_ch2,
   output logic [`QD_DATA_W-1:0] dac_code_ch3,
   output logic sense_ground_level,
   // AXI4-Lite slave
   input wire logic [`QD_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`QD_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   sys_state_type state_ff;
   sys_state_type nxt_state;

   logic [`QD_WORD_W-1:0] link_word;
   logic [`QD_SYNC_W-1:0] pins_sync;
   logic fs_n_s;
   logic load_n_s;
   logic clear_n_s;
   logic bypass_s;
   logic [4:0] straps_s;
   logic frame_end;
   logic [4:0] frame_pkg;
   logic [1:0] frame_ch;
   logic [`QD_DATA_W-1:0] frame_data;
   logic pkg_match;
   logic frame_accept;
   logic load_request;
   logic aw_take;
   logic w_take;
   logic ar_take;
   logic [`QD_ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_fire;
   logic wr_hit_ctrl;
   logic wr_hit_count;
   logic [31:0] rd_data;
   logic [1:0] rd_resp;

   // ****************************************************************
   // Link domain and pin synchronisers
   // ****************************************************************

   // Serial word is assembled on the serial clock
   qdac_serial_shifter u_shifter (
      .serial_clk(serial_clk),
      .frame_sync_n(frame_sync_n),
      .serial_data(serial_data),
      .shift_word(link_word)
   );

   // Strap, control and frame sync pins pass two flip-flops before use
   qdac_pin_sync u_pin_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .pins_async({package_id_straps, package_match_bypass, load_outputs_n,
                   output_clear_n, frame_sync_n}),
      .pins_sync(pins_sync)
   );

   // Straps are read continuously, not caught once at reset
   // package identity from straps
   assign straps_s = pins_sync[8:4];
   assign bypass_s = pins_sync[3];
   assign load_n_s = pins_sync[2];
   assign clear_n_s = pins_sync[1];
   assign fs_n_s = pins_sync[0];

   // ****************************************************************
   // Frame decode
   // ****************************************************************

   // The link word is read here without its own synchroniser. It only
   // moves on serial clock edges while frame_sync_n is low, so it stands
   // still from the rising frame edge through the two synchroniser stages
   // and the commit edge. A host that reopens a frame within four clk_sys
   // cycles breaks that hold and may commit a torn word.

   assign frame_end = fs_n_s & ~state_ff.fs_prev;

   assign frame_pkg = link_word[`QD_PKG_MSB:`QD_PKG_LSB];
   assign frame_ch = link_word[`QD_CH_MSB:`QD_CH_LSB];
   assign frame_data = link_word[`QD_DATA_MSB:`QD_DATA_LSB];

   assign pkg_match = bypass_s | (frame_pkg == straps_s);
   assign frame_accept = frame_end & pkg_match & state_ff.ctrl_enable;

   // Soft load from CTRL joins the pin; clear blocks both
   // load ignored while clear is low
   assign load_request = (~load_n_s | state_ff.soft_load) & clear_n_s;

   // ****************************************************************
   // AXI4-Lite handshakes
   // ****************************************************************

   // Each channel moves at the edge where its valid and ready meet. The
   // write answer follows one edge after both halves are in, the read
   // answer one edge after the address; both stand until their ready.

   // Address and data taken once each, in either order
   assign s_axi_awready = ~state_ff.aw_got & ~state_ff.bvalid;
   assign s_axi_wready = ~state_ff.w_got & ~state_ff.bvalid;
   assign s_axi_arready = ~state_ff.rvalid;
   assign aw_take = s_axi_awvalid & s_axi_awready;
   assign w_take = s_axi_wvalid & s_axi_wready;
   assign ar_take = s_axi_arvalid & s_axi_arready;

   // Write fires when both halves are present
   assign wr_addr = state_ff.aw_got ? state_ff.awaddr : s_axi_awaddr;
   assign wr_data = state_ff.w_got ? state_ff.wdata : s_axi_wdata;
   assign wr_strb = state_ff.w_got ? state_ff.wstrb : s_axi_wstrb;
   assign wr_fire = (state_ff.aw_got | aw_take) & (state_ff.w_got | w_take);

   // Only CTRL and COUNT accept writes; all else answers with an error
   assign wr_hit_ctrl = wr_fire & (wr_addr == `QD_OFF_CTRL);
   assign wr_hit_count = wr_fire & (wr_addr == `QD_OFF_COUNT);

   // Read data selection
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_resp = `QD_RESP_OKAY;
      case (s_axi_araddr)
         `QD_OFF_CTRL: begin
            rd_data[`QD_CTRL_ENABLE_BIT] = state_ff.ctrl_enable;
         end
         `QD_OFF_STATUS: begin
            rd_data[0] = (state_ff.mode == MODE_GROUND);
            rd_data[1] = load_n_s;
            rd_data[2] = clear_n_s;
            rd_data[3] = bypass_s;
            rd_data[8:4] = straps_s;
         end
         `QD_OFF_COUNT: begin
            rd_data = {state_ff.rej_cnt, state_ff.acc_cnt};
         end
         `QD_OFF_LAST: begin
            rd_data[`QD_WORD_W-1:0] = state_ff.last_word;
         end
         `QD_OFF_INPUT0: begin
            rd_data[`QD_DATA_W-1:0] = state_ff.in_reg[0];
         end
         `QD_OFF_INPUT0 + 8'h04: begin
            rd_data[`QD_DATA_W-1:0] = state_ff.in_reg[1];
         end
         `QD_OFF_INPUT0 + 8'h08: begin
            rd_data[`QD_DATA_W-1:0] = state_ff.in_reg[2];
         end
         `QD_OFF_INPUT0 + 8'h0c: begin
            rd_data[`QD_DATA_W-1:0] = state_ff.in_reg[3];
         end
         `QD_OFF_LATCH0: begin
            rd_data[`QD_DATA_W-1:0] = state_ff.latch[0];
         end
         `QD_OFF_LATCH0 + 8'h04: begin
            rd_data[`QD_DATA_W-1:0] = state_ff.latch[1];
         end
         `QD_OFF_LATCH0 + 8'h08: begin
            rd_data[`QD_DATA_W-1:0] = state_ff.latch[2];
         end
         `QD_OFF_LATCH0 + 8'h0c: begin
            rd_data[`QD_DATA_W-1:0] = state_ff.latch[3];
         end
         default: begin
            rd_resp = `QD_RESP_SLVERR;
         end
      endcase
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      nxt_state = state_ff;
      // Edge history; soft load lasts one cycle
      nxt_state.fs_prev = fs_n_s;
      nxt_state.soft_load = 1'b0;

      // A frame and a load in one cycle: the latch takes the old value now
      // and the new one on the next edge while load stays low
      // Rejected frames only count; LAST still records them
      // frame commit touches input registers, LAST and the counters, never the latches
      if (frame_end) begin
         nxt_state.last_word = link_word;
         if (frame_accept) begin
            nxt_state.in_reg[frame_ch] = frame_data;
            nxt_state.acc_cnt = state_ff.acc_cnt + 16'h0001;
         end else begin
            nxt_state.rej_cnt = state_ff.rej_cnt + 16'h0001;
         end
      end

      // Clear wins over any load in the same cycle
      // clear forces and holds ground mode
      if (!clear_n_s) begin
         nxt_state.mode = MODE_GROUND;
      end else if (load_request) begin
         // all latches load together, outputs go live
         nxt_state.mode = MODE_LIVE;
         nxt_state.latch = state_ff.in_reg;
      end

      // Write address channel capture
      if (aw_take && !wr_fire) begin
         nxt_state.aw_got = 1'b1;
         nxt_state.awaddr = s_axi_awaddr;
      end

      // Write data channel capture
      if (w_take && !wr_fire) begin
         nxt_state.w_got = 1'b1;
         nxt_state.wdata = s_axi_wdata;
         nxt_state.wstrb = s_axi_wstrb;
      end

      // Register write and response
      if (wr_fire) begin
         nxt_state.aw_got = 1'b0;
         nxt_state.w_got = 1'b0;
         nxt_state.bvalid = 1'b1;
         nxt_state.bresp = `QD_RESP_OKAY;
         if (wr_hit_ctrl) begin
            if (wr_strb[0]) begin
               nxt_state.ctrl_enable = wr_data[`QD_CTRL_ENABLE_BIT];
               nxt_state.soft_load = wr_data[`QD_CTRL_SOFT_LOAD_BIT];
            end
         end else if (wr_hit_count) begin
            nxt_state.acc_cnt = 16'h0000;
            nxt_state.rej_cnt = 16'h0000;
         end else begin
            nxt_state.bresp = `QD_RESP_SLVERR;
         end
      end else if (state_ff.bvalid && s_axi_bready) begin
         nxt_state.bvalid = 1'b0;
      end

      // Read response
      // Read data is caught at acceptance so it stands until rready
      if (ar_take) begin
         nxt_state.rvalid = 1'b1;
         nxt_state.rdata = rd_data;
         nxt_state.rresp = rd_resp;
      end else if (state_ff.rvalid && s_axi_rready) begin
         nxt_state.rvalid = 1'b0;
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         // Ground mode and frame enable out of reset
         state_ff <= '0;
         state_ff.mode <= MODE_GROUND;
         state_ff.ctrl_enable <= `QD_CTRL_ENABLE_RST;
         state_ff.fs_prev <= 1'b1;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************

   // Latched codes drive the converters
   assign dac_code_ch0 = state_ff.latch[0];
   assign dac_code_ch1 = state_ff.latch[1];
   assign dac_code_ch2 = state_ff.latch[2];
   assign dac_code_ch3 = state_ff.latch[3];

   assign sense_ground_level = (state_ff.mode == MODE_GROUND);

   // Registered bus answers
   assign s_axi_bvalid = state_ff.bvalid;
   assign s_axi_bresp = state_ff.bresp;
   assign s_axi_rvalid = state_ff.rvalid;
   assign s_axi_rdata = state_ff.rdata;
   assign s_axi_rresp = state_ff.rresp;

endmodule : qdac_serial_load_ctrl

// ==== hdl/qdac_defines.svh ====
/*
 * Constants of the quad DAC serial load controller: frame layout, widths,
 * register offsets and reset values.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef QDAC_DEFINES_SVH
`define QDAC_DEFINES_SVH

// ****************************************************************
// Frame layout
// ****************************************************************
`define QD_WORD_W 24
`define QD_DATA_W 14
`define QD_NUM_CH 4
`define QD_PKG_MSB 23
`define QD_PKG_LSB 19
`define QD_CH_MSB 18
`define QD_CH_LSB 17
`define QD_DATA_MSB 13
`define QD_DATA_LSB 0

// ****************************************************************
// Pin synchroniser layout
// ****************************************************************
`define QD_SYNC_W 9
`define QD_SYNC_RST 9'h1ff

// ****************************************************************
// Register map, byte addresses
// ****************************************************************
`define QD_ADDR_W 8
`define QD_OFF_CTRL 8'h00
`define QD_OFF_STATUS 8'h04
`define QD_OFF_COUNT 8'h08
`define QD_OFF_LAST 8'h0c
`define QD_OFF_INPUT0 8'h10
`define QD_OFF_LATCH0 8'h20

// ****************************************************************
// Control fields and reset values
// ****************************************************************
`define QD_CTRL_ENABLE_BIT 0
`define QD_CTRL_SOFT_LOAD_BIT 1
`define QD_CTRL_ENABLE_RST 1'h1
`define QD_RESP_OKAY 2'h0
`define QD_RESP_SLVERR 2'h2

`endif

// ==== hdl/qdac_pkg.sv ====
/*
 * Types of the quad DAC serial load controller.
 * Assumes qdac_defines.svh on the include path.
 */
`include "qdac_defines.svh"

package qdac_pkg;

   // Analog output source
   typedef enum logic [1:0] {
      MODE_LIVE = 2'b01,
      MODE_GROUND = 2'b10
   } out_mode_type;

   typedef logic [`QD_DATA_W-1:0] code_type;

   // All system-domain state of the top module
   typedef struct packed {
      out_mode_type mode;
      logic ctrl_enable;
      logic soft_load;
      logic [`QD_NUM_CH-1:0][`QD_DATA_W-1:0] in_reg;
      logic [`QD_NUM_CH-1:0][`QD_DATA_W-1:0] latch;
      logic [`QD_WORD_W-1:0] last_word;
      logic [15:0] acc_cnt;
      logic [15:0] rej_cnt;
      logic fs_prev;
      logic aw_got;
      logic [`QD_ADDR_W-1:0] awaddr;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } sys_state_type;

endpackage : qdac_pkg

// ==== hdl/qdac_pin_sync.sv ====
/*
 * Two flip-flop synchroniser for a group of level pins.
 * Assumes pins are static or slow relative to clk_sys.
 */
`timescale 1ns/100ps
`include "qdac_defines.svh"

module qdac_pin_sync (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [`QD_SYNC_W-1:0] pins_async,
   output logic [`QD_SYNC_W-1:0] pins_sync
);

   typedef struct packed {
      logic [`QD_SYNC_W-1:0] stage1;
      logic [`QD_SYNC_W-1:0] stage2;
   } sync_state_type;

   sync_state_type state_ff;
   sync_state_type nxt_state;

   // First stage feeds only the second stage
   always_comb begin
      nxt_state = state_ff;
      nxt_state.stage1 = pins_async;
      nxt_state.stage2 = state_ff.stage1;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_ff <= {`QD_SYNC_RST, `QD_SYNC_RST};
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign pins_sync = state_ff.stage2;

endmodule : qdac_pin_sync

// ==== hdl/qdac_serial_shifter.sv ====
/*
 * Link-domain serial input register of the quad DAC controller.
 * Assumes the serial clock may stop between frames; data moves only
 * while frame_sync_n is low, so the word holds still once it rises.
 */
`timescale 1ns/100ps
`include "qdac_defines.svh"

module qdac_serial_shifter (
   input wire logic serial_clk,
   input wire logic frame_sync_n,
   input wire logic serial_data,
   output logic [`QD_WORD_W-1:0] shift_word
);

   typedef struct packed {
      logic [`QD_WORD_W-1:0] word;
   } shift_state_type;

   shift_state_type state_ff;
   shift_state_type nxt_state;

   // Shift MSB first while framed; last 24 bits of a frame remain
   always_comb begin
      nxt_state = state_ff;
      if (!frame_sync_n) begin
         nxt_state.word = {state_ff.word[`QD_WORD_W-2:0], serial_data};
      end
   end

   always_ff @(negedge serial_clk) begin
      state_ff <= nxt_state;
   end

   assign shift_word = state_ff.word;

endmodule : qdac_serial_shifter

// ==== dv/qdac_host_model.sv ====
/*
 * Host serial port model: frames 24-bit words onto the serial link.
 * Assumes tb calls send and leaves frame_sync_n high long enough.
 */
`timescale 1ns/100ps

// ****************************************
// Host serial port
// ****************************************
module qdac_host_model (
   output logic serial_clk,
   output logic serial_data,
   output logic frame_sync_n
);
   // Link idles with clock stopped
   initial begin
      serial_clk = 1'b0;
      serial_data = 1'b0;
      frame_sync_n = 1'b1;
   end

   // One frame, MSB first, 160 ns link period
   task automatic send(input logic [23:0] w);
      #1.7;
      frame_sync_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         #20 serial_data = w[i];
         #20 serial_clk = 1'b1;
         #80 serial_clk = 1'b0;
         #40;
      end
      frame_sync_n = 1'b1;
      serial_data = ~serial_data; // Released line shows no stale bit
      #40;
   endtask : send
endmodule : qdac_host_model

// ==== dv/qdac_serial_load_ctrl_checker.sv ====
/*
 * Load and clear checks on the top module ports.
 * Assumes pins pass a two-stage synchroniser ahead of the state.
 */
`timescale 1ns/100ps

// ****************************************
// Checker
// ****************************************
module qdac_serial_load_ctrl_checker (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic frame_sync_n,
   input wire logic load_outputs_n,
   input wire logic output_clear_n,
   input wire logic s_axi_wvalid,
   input wire logic [13:0] dac_code_ch0,
   input wire logic [13:0] dac_code_ch1,
   input wire logic [13:0] dac_code_ch2,
   input wire logic [13:0] dac_code_ch3,
   input wire logic sense_ground_level
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic [55:0] codes;

   // All four output codes together
   assign codes = {dac_code_ch3, dac_code_ch2, dac_code_ch1, dac_code_ch0};

   property p_hold; (load_outputs_n && !s_axi_wvalid) [*3] |=> $stable(codes); endproperty
   a_hold: assert property (p_hold) else $error("Codes moved with load high");
   property p_live; (!load_outputs_n && output_clear_n) [*4] |=> !sense_ground_level; endproperty
   a_live: assert property (p_live) else $error("Load did not end ground");
   property p_gnd; !output_clear_n [*3] |=> sense_ground_level; endproperty
   a_gnd: assert property (p_gnd) else $error("Clear did not ground");
   property p_cause; $rose(sense_ground_level) |-> !$past(output_clear_n, 3); endproperty
   a_cause: assert property (p_cause) else $error("Ground without clear");
   property p_keep;
      (load_outputs_n && !s_axi_wvalid) [*3] ##0 sense_ground_level |=> sense_ground_level;
   endproperty
   a_keep: assert property (p_keep) else $error("Ground left without load");
   property p_back;
      ($rose(output_clear_n) && !load_outputs_n) ##1 (output_clear_n && !load_outputs_n) [*4]
      |=> !sense_ground_level;
   endproperty
   a_back: assert property (p_back) else $error("Outputs not back after clear");
   property p_frz; !output_clear_n [*3] |=> $stable(codes); endproperty
   a_frz: assert property (p_frz) else $error("Codes moved under clear");
   property p_beat;
      (!output_clear_n && !load_outputs_n) [*3] ##1 !output_clear_n
      |=> sense_ground_level && $stable(dac_code_ch1);
   endproperty
   a_beat: assert property (p_beat) else $error("Load acted under clear");
   c_live: cover property ($fell(sense_ground_level));
   c_gnd: cover property ($rose(sense_ground_level));
   c_frame: cover property ($rose(frame_sync_n) && !load_outputs_n);
endmodule : qdac_serial_load_ctrl_checker

bind qdac_serial_load_ctrl qdac_serial_load_ctrl_checker chk (.*);

// ==== dv/tb.sv ====
/*
 * Bench: frames from the host model, register checks over AXI4-Lite.
 * Assumes commit within 4 clk_sys edges of frame end, 2-flop pins.
 */
`timescale 1ns/100ps
`include "qdac_defines.svh"
`define chk(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end

// ****************************************
// Testbench top
// ****************************************
module tb;
   import qdac_pkg::*;
   int n_checks = 0;
   int n_mismatch = 0;
   logic clk_sys = 1'b0, rst = 1'b1, serial_clk, serial_data, frame_sync_n;
   logic [4:0] package_id_straps = 5'h0a;
   logic package_match_bypass = 1'b0, load_outputs_n = 1'b1, output_clear_n = 1'b1;
   logic [13:0] dac_code_ch0, dac_code_ch1, dac_code_ch2, dac_code_ch3;
   logic sense_ground_level, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [55:0] c1;

   qdac_serial_load_ctrl uut (.*);
   qdac_host_model host (.*);

   always #2.5 clk_sys = ~clk_sys;

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      `chk("bresp", er, s_axi_bresp)
      `chk("wready", 2'h0, {s_axi_awready, s_axi_wready})
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      `chk("arready", 1'b0, s_axi_arready)
      `chk("rdata", e, s_axi_rdata)
      `chk("rresp", er, s_axi_rresp)
   endtask : rd

   // Frame, then the sync and commit edges
   task automatic frm(input logic [4:0] p, input logic [1:0] c, input logic [13:0] d);
      host.send({p, c, 3'h0, d});
      repeat (6) @(posedge clk_sys);
   endtask : frm

   task automatic settle;
      repeat (6) @(posedge clk_sys);
   endtask : settle

   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : give_verdict

   // Main sequence
   initial begin
      c1 = {14'h1003, 14'h1002, 14'h3333, 14'h1000};
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      settle();
      rd(`QD_OFF_STATUS, 32'h0a7, `QD_RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         frm(5'h0a, 2'(i), 14'h1000 + 14'(i));
         rd(8'h10 + 8'(4 * i), 32'h1000 + 32'(i), `QD_RESP_OKAY);
      end
      `chk("codes", 56'h0, {dac_code_ch3, dac_code_ch2, dac_code_ch1, dac_code_ch0})
      frm(5'h0b, 2'h1, 14'h2222);
      rd(8'h14, 32'h1001, `QD_RESP_OKAY);
      rd(`QD_OFF_COUNT, 32'h0001_0004, `QD_RESP_OKAY);
      package_match_bypass <= 1'b1;
      frm(5'h15, 2'h1, 14'h3333);
      rd(8'h14, 32'h3333, `QD_RESP_OKAY);
      package_match_bypass <= 1'b0;
      load_outputs_n <= 1'b0;
      settle();
      `chk("codes", c1, {dac_code_ch3, dac_code_ch2, dac_code_ch1, dac_code_ch0})
      `chk("ground", 1'b0, sense_ground_level)
      load_outputs_n <= 1'b1;
      frm(5'h0a, 2'h0, 14'h0abc);
      rd(`QD_OFF_LATCH0, 32'h1000, `QD_RESP_OKAY);
      output_clear_n <= 1'b0;
      settle();
      `chk("ground", 1'b1, sense_ground_level)
      load_outputs_n <= 1'b0;
      settle();
      `chk("codes", c1, {dac_code_ch3, dac_code_ch2, dac_code_ch1, dac_code_ch0})
      `chk("ground", 1'b1, sense_ground_level)
      load_outputs_n <= 1'b1;
      output_clear_n <= 1'b1;
      settle();
      `chk("ground", 1'b1, sense_ground_level)
      load_outputs_n <= 1'b0;
      settle();
      c1[13:0] = 14'h0abc;
      `chk("codes", c1, {dac_code_ch3, dac_code_ch2, dac_code_ch1, dac_code_ch0})
      output_clear_n <= 1'b0;
      settle();
      output_clear_n <= 1'b1;
      settle();
      `chk("ground", 1'b0, sense_ground_level)
      package_id_straps <= 5'h11;
      frm(5'h11, 2'h3, 14'h0777);
      `chk("code3", 14'h0777, dac_code_ch3)
      load_outputs_n <= 1'b1;
      frm(5'h11, 2'h0, 14'h0123);
      `chk("code0", 14'h0abc, dac_code_ch0)
      s_axi_wstrb <= 4'he;
      wr(`QD_OFF_CTRL, 32'h2, `QD_RESP_OKAY);
      settle();
      `chk("code0", 14'h0abc, dac_code_ch0)
      s_axi_wstrb <= 4'hf;
      wr(`QD_OFF_CTRL, 32'h3, `QD_RESP_OKAY);
      settle();
      `chk("code0", 14'h0123, dac_code_ch0)
      rd(`QD_OFF_CTRL, 32'h1, `QD_RESP_OKAY);
      wr(`QD_OFF_COUNT, 32'h0, `QD_RESP_OKAY);
      rd(`QD_OFF_COUNT, 32'h0, `QD_RESP_OKAY);
      wr(`QD_OFF_STATUS, 32'h1, `QD_RESP_SLVERR);
      rd(8'h30, 32'h0, `QD_RESP_SLVERR);
      wr(`QD_OFF_CTRL, 32'h0, `QD_RESP_OKAY);
      frm(5'h11, 2'h2, 14'h0555);
      rd(8'h18, 32'h1002, `QD_RESP_OKAY);
      rd(`QD_OFF_COUNT, 32'h0001_0000, `QD_RESP_OKAY);
      rd(`QD_OFF_LAST, 32'h008c_0555, `QD_RESP_OKAY);
      give_verdict();
   end

   // Watchdog on a hung handshake
   initial begin
      #100000;
      n_mismatch++;
      give_verdict();
   end
endmodule : tb
